// >>> common/vss_pkg.sv
// package: constants and carriers for the vertical sync separator
package vss_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 200_000_000;
    localparam int unsigned TICK_HZ     = 5_000_000;
    localparam int unsigned TICK_DIV    = CLK_HZ / TICK_HZ;
    localparam logic [5:0]  TICK_LAST   = 6'(TICK_DIV - 1);

    // ------------------------------------------------------------
    // counter and register layout
    // ------------------------------------------------------------
    localparam int unsigned CNT_W       = 8;
    localparam logic [7:0]  CNT_MAX     = 8'hff;
    localparam logic [7:0]  CNT_ZERO    = 8'h00;
    localparam logic [7:0]  TRIG_ADDR   = 8'h11;
    localparam logic [7:0]  SEL_ADDR    = 8'h0e;
    localparam int unsigned SEL_BIT     = 0;
    localparam logic [7:0]  TRIG_RESET  = 8'h20;
    localparam logic        SEL_RESET   = 1'b0;

    // ------------------------------------------------------------
    // states and carriers
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        VSS_SEEK  = 1'b0,
        VSS_INVSY = 1'b1
    } vss_state_t;

    typedef struct packed {
        logic [7:0] trigger;
        logic       use_separator;
    } vss_cfg_t;

    typedef struct packed {
        logic       vsync;
        logic [7:0] count;
    } vss_stat_t;

endpackage

// >>> rtl/vss_separator.sv
// module: vertical sync separator with output selector
`timescale 1ns/1ps
// How it works
// R01 - an 8-bit counter steps once per 5 MHz tick, 200 ns a count.
// R02 - the composite input is active-high; polarity is fixed upstream.
// R03 - while the composite input is active the counter counts up each tick.
// R04 - after the pulse ends the counter counts down each tick toward zero.
// R05 - vertical sync is declared when the count exceeds the trigger count.
// R06 - at detection the count clears, then rises only while input is idle.
// R07 - vertical sync ends when the idle count reaches the trigger count.
// R08 - on end of sync the counter clears and accumulation starts over.
// R09 - select bit low passes the direct vsync, high the separated sync.
// R10 - the counter saturates at 255 and at zero instead of wrapping.
// R11 - the separated output is high from detection until absence.

module vss_separator (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // configuration from the control registers
    input  wire vss_pkg::vss_cfg_t cfg,
    // sync inputs (pins)
    input  wire logic              csync,
    input  wire logic              vsync_in,
    // outputs
    output logic                   vsync_out,
    output vss_pkg::vss_stat_t     stat
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0]          cs_sync;
    logic [1:0]          vs_sync;
    logic                cs;
    logic                vs;
    logic                tick;
    logic [7:0]          count;
    logic [7:0]          next_count;
    vss_pkg::vss_state_t state;
    vss_pkg::vss_state_t next_state;

    // pins are asynchronous to clk; two flops before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_sync <= 2'b00;
            vs_sync <= 2'b00;
        end else begin
            cs_sync <= {cs_sync[0], csync};
            vs_sync <= {vs_sync[0], vsync_in};
        end
    end

    assign cs = cs_sync[1]; // R02
    assign vs = vs_sync[1];

    // ------------------------------------------------------------
    // tick
    // ------------------------------------------------------------
    vss_tick i_vss_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // saturating step; avoids wrap that would fake a long pulse
    function automatic logic [7:0] sat_up(input logic [7:0] v);
        sat_up = (v == vss_pkg::CNT_MAX) ? v : v + 8'h01; // R10
    endfunction

    function automatic logic [7:0] sat_dn(input logic [7:0] v);
        sat_dn = (v == vss_pkg::CNT_ZERO) ? v : v - 8'h01; // R10
    endfunction

    // ------------------------------------------------------------
    // next state and count
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_count = count;
        if (tick) begin
            case (state)
                vss_pkg::VSS_SEEK: begin
                    if (cs) begin
                        next_count = sat_up(count); // R01 R03
                    end else begin
                        next_count = sat_dn(count); // R04
                    end
                    if (count > cfg.trigger) begin
                        next_state = vss_pkg::VSS_INVSY; // R05
                        next_count = vss_pkg::CNT_ZERO;  // R06
                    end
                end
                vss_pkg::VSS_INVSY: begin
                    if (count >= cfg.trigger) begin
                        next_state = vss_pkg::VSS_SEEK; // R07
                        next_count = vss_pkg::CNT_ZERO; // R08
                    end else if (!cs) begin
                        next_count = sat_up(count);     // R06
                    end
                end
                default: begin
                    next_state = vss_pkg::VSS_SEEK;
                    next_count = vss_pkg::CNT_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // decisions only move on ticks, so a noise glitch between ticks
    // costs at most one count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= vss_pkg::VSS_SEEK;
            count <= vss_pkg::CNT_ZERO;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // output selector
    // ------------------------------------------------------------
    // registered so the output never glitches on a select change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vsync_out <= 1'b0;
        end else if (cfg.use_separator) begin
            vsync_out <= (next_state == vss_pkg::VSS_INVSY); // R09 R11
        end else begin
            vsync_out <= vs; // R09
        end
    end

    assign stat.vsync = (state == vss_pkg::VSS_INVSY); // R11
    assign stat.count = count;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_hold_no_tick: assert property (@(posedge clk) disable iff (rst) // R01
        !tick |=> $stable(count))
        else $error("count moved without a tick");

    a_count_up: assert property (@(posedge clk) disable iff (rst) // R03
        tick && state == vss_pkg::VSS_SEEK && cs && count <= cfg.trigger
        && count != vss_pkg::CNT_MAX |=> count == $past(count) + 8'h01)
        else $error("count did not rise during pulse");

    a_count_down: assert property (@(posedge clk) disable iff (rst) // R04
        tick && state == vss_pkg::VSS_SEEK && !cs && count != 8'h00
        && count <= cfg.trigger |=> count == $past(count) - 8'h01)
        else $error("count did not fall after pulse");

    a_detect: assert property (@(posedge clk) disable iff (rst) // R05
        tick && state == vss_pkg::VSS_SEEK && count > cfg.trigger
        |=> state == vss_pkg::VSS_INVSY && count == 8'h00)
        else $error("sync not detected above trigger");

    a_inv_hold: assert property (@(posedge clk) disable iff (rst) // R06
        tick && state == vss_pkg::VSS_INVSY && cs && count < cfg.trigger
        |=> $stable(count))
        else $error("count moved while sync active");

    a_absence: assert property (@(posedge clk) disable iff (rst) // R07
        tick && state == vss_pkg::VSS_INVSY && count >= cfg.trigger
        |=> state == vss_pkg::VSS_SEEK && count == 8'h00)
        else $error("sync absence not taken at trigger");

    a_no_wrap: assert property (@(posedge clk) disable iff (rst) // R10
        $past(count) == vss_pkg::CNT_MAX |-> count != 8'h00
        || $past(state) != state)
        else $error("counter wrapped");

    a_out_sel: assert property (@(posedge clk) disable iff (rst) // R09
        cfg.use_separator ##1 cfg.use_separator
        |-> vsync_out == stat.vsync)
        else $error("selected output mismatch");

    a_out_pass: assert property (@(posedge clk) disable iff (rst) // R09
        !cfg.use_separator |=> vsync_out == $past(vs))
        else $error("direct vsync not passed");

    a_low_seek: assert property (@(posedge clk) disable iff (rst) // R08 R11
        state == vss_pkg::VSS_SEEK && $past(state) == vss_pkg::VSS_SEEK
        && cfg.use_separator && $past(cfg.use_separator)
        |-> !vsync_out)
        else $error("output high while seeking");

    // a held pulse at the top must not wrap and fake a fresh short pulse
    a_sat_top: assert property (@(posedge clk) disable iff (rst) // R10
        tick && state == vss_pkg::VSS_SEEK && cs
        && count == vss_pkg::CNT_MAX && count <= cfg.trigger
        |=> count == vss_pkg::CNT_MAX)
        else $error("count left the top while held");

    a_sat_floor: assert property (@(posedge clk) disable iff (rst) // R10
        tick && state == vss_pkg::VSS_SEEK && !cs
        && count == vss_pkg::CNT_ZERO
        |=> count == vss_pkg::CNT_ZERO)
        else $error("count left zero while idle");

    a_inv_count: assert property (@(posedge clk) disable iff (rst) // R06
        tick && state == vss_pkg::VSS_INVSY && !cs && count < cfg.trigger
        |=> count == $past(count) + 8'h01)
        else $error("idle time not counted during sync");

    // the selector is fed from the next state, so the separated output
    // rises on the same edge as the state register, not one later
    a_sep_rise: assert property (@(posedge clk) disable iff (rst) // R11
        cfg.use_separator && tick && state == vss_pkg::VSS_SEEK
        && count > cfg.trigger |=> vsync_out)
        else $error("separated output did not rise on detection");

    c_detect: cover property (@(posedge clk) disable iff (rst)
        state == vss_pkg::VSS_SEEK ##1 state == vss_pkg::VSS_INVSY);
    c_absence: cover property (@(posedge clk) disable iff (rst)
        state == vss_pkg::VSS_INVSY ##1 state == vss_pkg::VSS_SEEK);
    c_saturate: cover property (@(posedge clk) disable iff (rst)
        count == vss_pkg::CNT_MAX);
    c_hpulse: cover property (@(posedge clk) disable iff (rst)
        count == 8'h05 && !cs);
    c_serration: cover property (@(posedge clk) disable iff (rst)
        tick && state == vss_pkg::VSS_INVSY && !cs);

endmodule

// >>> rtl/vss_tick.sv
// module: 5 MHz tick generator for the separator counter
`timescale 1ns/1ps

module vss_tick (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // tick out
    output logic      tick
);

    logic [5:0] div;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // one-cycle pulse every TICK_DIV clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div  <= 6'h00;
            tick <= 1'b0;
        end else begin
            tick <= (div == vss_pkg::TICK_LAST);
            if (div == vss_pkg::TICK_LAST) begin
                div <= 6'h00;
            end else begin
                div <= div + 6'h01;
            end
        end
    end

    a_tick_period: assert property (@(posedge clk) disable iff (rst) // R01
        tick |=> !tick [*8])
        else $error("tick came sooner than its period");

endmodule

// >>> test/tb_vss_separator.sv
// testbench: vertical sync separator against a tick-level reference
`timescale 1ns/1ps

module tb_vss_separator;
    logic               clk;
    logic               rst;
    vss_pkg::vss_cfg_t  cfg;
    logic               raw_sync;
    logic               raw_neg;
    logic               csync;
    logic               vsync_in;
    logic               vsync_out;
    vss_pkg::vss_stat_t stat;
    int                 n_fail;
    int                 total_checks;
    logic [31:0]        seed;
    logic               m_vs;
    logic [7:0]         m_cnt;

    vss_slicer_model i_vss_slicer_model (
        .raw_sync (raw_sync),
        .raw_neg  (raw_neg),
        .csync    (csync)
    );

    vss_separator i_vss_separator (
        .clk       (clk),
        .rst       (rst),
        .cfg       (cfg),
        .csync     (csync),
        .vsync_in  (vsync_in),
        .vsync_out (vsync_out),
        .stat      (stat)
    );

    // ------------------------------------------------------------
    // clock, reference and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // one 5 MHz tick of the separator; threshold is tested before stepping
    function automatic logic [8:0] ref_tick(input logic vs,
        input logic [7:0] cnt, input logic c, input logic [7:0] t);
        if (!vs) begin
            if (cnt > t) return 9'h100;
            if (c) return {1'b0, (cnt == 8'hff) ? cnt : cnt + 8'h01};
            return {1'b0, (cnt == 8'h00) ? cnt : cnt - 8'h01};
        end
        if (cnt >= t) return 9'h000;
        return {1'b1, (!c && cnt != 8'hff) ? cnt + 8'h01 : cnt};
    endfunction

    task automatic check(input string what, input logic [8:0] exp,
        input logic [8:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // drive at a falling edge mid-period, let one tick pass, compare mid-period
    task automatic step(input logic c, input logic neg, input logic sel,
        input logic vin);
        raw_neg = neg;
        raw_sync = c ^ neg;
        cfg.use_separator = sel;
        vsync_in = vin;
        repeat (40) @(posedge clk);
        @(negedge clk);
        {m_vs, m_cnt} = ref_tick(m_vs, m_cnt, c, cfg.trigger);
        check("stat", {m_vs, m_cnt}, stat);
        check("vsync_out", 9'(sel ? m_vs : vin), 9'(vsync_out));
    endtask

    task automatic burst(input int n, input logic c, input logic neg,
        input logic sel, input logic vin);
        repeat (n) step(c, neg, sel, vin);
    endtask

    task automatic results();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        total_checks = 0;
        seed = 32'h8eb6c915;
        rst = 1'b1;
        cfg = '{trigger: 8'h00, use_separator: 1'b1};
        raw_sync = 1'b0;
        raw_neg = 1'b0;
        vsync_in = 1'b0;
        m_vs = 1'b0;
        m_cnt = 8'h00;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("reset", 9'h000, {vsync_out, stat.count});
        rst = 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        // zero trigger: detect on the tick after the first count, drop on the next
        burst(4, 1'b1, 1'b0, 1'b1, 1'b0);
        // top trigger can never be exceeded, so the count pins at both ends
        cfg.trigger = 8'hff;
        burst(260, 1'b1, 1'b1, 1'b1, 1'b0);
        burst(260, 1'b0, 1'b0, 1'b0, 1'b1);
        // short line-like pulses decay away and are rejected
        cfg.trigger = 8'h08;
        repeat (8) begin
            burst(5, 1'b1, 1'b0, 1'b1, 1'b0);
            burst(10, 1'b0, 1'b1, 1'b1, 1'b0);
        end
        // long pulse with serrations inside the detected interval
        burst(12, 1'b1, 1'b0, 1'b1, 1'b0);
        repeat (3) begin
            burst(1, 1'b0, 1'b0, 1'b1, 1'b1);
            burst(1, 1'b1, 1'b0, 1'b0, 1'b1);
        end
        burst(12, 1'b0, 1'b0, 1'b1, 1'b0);
        // random traffic, biased high so detections happen
        for (int i = 0; i < 800; i++) begin
            seed = xorshift(seed);
            if (i % 100 == 0) begin
                cfg.trigger = {4'h0, seed[11:8]};
            end
            step(seed[0] | seed[1], seed[2], seed[3], seed[4]);
        end
        results();
    end

    // a hang is cut short well after the expected 60k cycles
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule

// >>> test/vss_slicer_model.sv
// model: sync slicer that hands a polarity-normalised composite sync on
`timescale 1ns/1ps

module vss_slicer_model (
    // raw sliced sync and its polarity from the board
    input  wire logic raw_sync,
    input  wire logic raw_neg,
    // normalised composite sync, active high
    output logic      csync
);
    // fold polarity here so the separator only ever sees high-true pulses
    assign csync = raw_sync ^ raw_neg;
endmodule
